// >>> core/tdc_cfg_defs.vh
// register offsets, field positions, reset values and sizes of the configuration block
`ifndef TDC_CFG_DEFS_VH
`define TDC_CFG_DEFS_VH

`define ADDR_W                 5
`define OFS_STOP_TIMING_CONFIG 5'h00
`define OFS_FIRST_WAVE_CONFIG  5'h04
`define OFS_IRQ_STATUS         5'h08
`define OFS_IRQ_MASK           5'h0C
`define OFS_CORE_STATUS        5'h10

`define RESP_OKAY              2'h0
`define RESP_SLVERR            2'h2

// stop_timing_config fields
`define STC_IRQ_TIMEOUT_BIT    31
`define STC_IRQ_HITS_BIT       30
`define STC_IRQ_CALC_BIT       29
`define STC_DUAL_EDGE_BIT      28
`define STC_DELAY_MSB          21
`define STC_DELAY_LSB          6
`define STC_OFFSET_MSB         5
`define STC_OFFSET_LSB         0
`define STC_RESET              32'h20000000

// first_wave_config fields
`define FWC_ENABLE_BIT         31
`define FWC_EDGE_BIT           30
`define FWC_STOP1_LSB          24
`define FWC_STOP2_LSB          18
`define FWC_STOP3_LSB          12
`define FWC_STOP4_LSB          6
`define FWC_STOP5_LSB          0
`define FWC_COUNT_W            6
`define FWC_RESET              32'h00000000

// interrupt status / mask layout
`define IRQ_TIMEOUT_BIT        0
`define IRQ_HITS_BIT           1
`define IRQ_CALC_BIT           2
`define IRQ_W                  3
`define IRQ_MASK_RESET         3'h7

// comparator offset step, stop count and stop-1 delay field width
`define OFFSET_STEP_MV         4
`define NUM_STOPS              5
`define DELAY_W                16

`endif

// >>> core/period_counter.v
// loadable down counter that gives one pulse when its programmed count of ticks has passed
`timescale 1ns/1ps
module period_counter #(
  parameter W = 16
) (
  input  wire         mclk_i,
  input  wire         srst_i,
  input  wire         load_i,
  input  wire [W-1:0] load_val_i,
  input  wire         tick_i,
  input  wire         abort_i,
  output wire         busy_o,
  output wire         fire_o
);

  reg [W-1:0] cnt_reg;
  reg         armed_reg;
  reg         fire_reg;

  always @(posedge mclk_i) begin
    if (srst_i || abort_i) begin
      cnt_reg   <= {W{1'b0}};
      armed_reg <= 1'b0;
      fire_reg  <= 1'b0;
    end else if (load_i) begin
      // a zero count has already elapsed, so it fires straight away
      cnt_reg   <= load_val_i;
      armed_reg <= (load_val_i != {W{1'b0}});
      fire_reg  <= (load_val_i == {W{1'b0}});
    end else if (armed_reg && tick_i) begin
      if (cnt_reg == {{(W-1){1'b0}}, 1'b1}) begin
        armed_reg <= 1'b0;
        fire_reg  <= 1'b1;
      end else begin
        fire_reg  <= 1'b0;
      end
      cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
    end else begin
      fire_reg <= 1'b0;
    end
  end

  assign busy_o = armed_reg;
  assign fire_o = fire_reg;

endmodule // period_counter

// >>> core/tdc_stop_firstwave_config.v
// configuration words for stop timing and first-wave detection, with AXI4-Lite access
//
// Contract
// - stop input held off for hit 1 until programmed delay after start elapses.
// - the 16-bit delay counts whole reference clock periods, integer only.
// - 6-bit comparator offset is two's complement in 4 mV steps.
// - edge-mode 0 means one hit edge, 1 means both edges.
// - top bit of second word turns automatic first-hit detection on or off.
// - other first-wave fields only act while first-hit detection is enabled.
// - first-wave edge bit: 0 rising, 1 falling.
// - stops 1..5 taken programmed periods after first hit; host keeps ranges.
// - configuration words are write-only; host keeps its own copy.
//
// The AXI4-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "tdc_cfg_defs.vh"
module tdc_stop_firstwave_config (
  input  wire                       mclk_i,
  input  wire                       srst_i,
  // AXI4-Lite slave
  input  wire [`ADDR_W-1:0]         s_axi_awaddr,
  input  wire                       s_axi_awvalid,
  output wire                       s_axi_awready,
  input  wire [31:0]                s_axi_wdata,
  input  wire [3:0]                 s_axi_wstrb,
  input  wire                       s_axi_wvalid,
  output wire                       s_axi_wready,
  output wire [1:0]                 s_axi_bresp,
  output wire                       s_axi_bvalid,
  input  wire                       s_axi_bready,
  input  wire [`ADDR_W-1:0]         s_axi_araddr,
  input  wire                       s_axi_arvalid,
  output wire                       s_axi_arready,
  output wire [31:0]                s_axi_rdata,
  output wire [1:0]                 s_axi_rresp,
  output wire                       s_axi_rvalid,
  input  wire                       s_axi_rready,
  // measurement side
  input  wire                       start_i,
  input  wire                       hit_i,
  input  wire                       timeout_evt_i,
  input  wire                       hits_done_evt_i,
  input  wire                       calc_done_evt_i,
  output wire                       stop1_enable_o,
  output wire                       hit_edge_o,
  output wire                       first_wave_seen_o,
  output wire [`NUM_STOPS-1:0]      stop_pulse_o,
  output wire signed [7:0]          comp_offset_mv_o,
  output wire                       irq_o
);

  localparam ST_IDLE  = 3'h1;
  localparam ST_WAIT  = 3'h2;
  localparam ST_COUNT = 3'h4;

  // picks the edge event for a given polarity select
  function edge_pick;
    input rise;
    input fall;
    input sel_fall;
    begin
      edge_pick = sel_fall ? fall : rise;
    end
  endfunction

  // byte-lane merge for the two configuration words
  function [31:0] lane_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0]  strb;
    integer k;
    begin
      lane_merge = old_val;
      for (k = 0; k < 4; k = k + 1) begin
        if (strb[k]) begin
          lane_merge[k*8 +: 8] = new_val[k*8 +: 8];
        end
      end
    end
  endfunction

  reg  [31:0]              stop_timing_config_reg;
  reg  [31:0]              first_wave_config_reg;
  reg  [`IRQ_W-1:0]        irq_status_reg;
  reg  [`IRQ_W-1:0]        irq_mask_reg;
  reg  [`IRQ_W-1:0]        irq_status_next;

  reg                      aw_held_reg;
  reg  [`ADDR_W-1:0]       aw_addr_reg;
  reg                      w_held_reg;
  reg  [31:0]              w_data_reg;
  reg  [3:0]               w_strb_reg;
  reg                      bvalid_reg;
  reg  [1:0]               bresp_reg;
  reg                      rvalid_reg;
  reg  [31:0]              rdata_reg;
  reg  [1:0]               rresp_reg;

  reg                      hit_d_reg;
  reg                      stop1_en_reg;
  reg                      fw_seen_reg;
  reg  [2:0]               state_reg;
  reg  [2:0]               state_next;
  reg  signed [7:0]        offset_mv_reg;
  reg  [`NUM_STOPS-1:0]    stop_done_reg;

  wire                     wr_go;
  wire                     rd_go;
  wire                     irq_timeout_allow;
  wire                     irq_hits_allow;
  wire                     irq_calc_done_allow;
  wire                     dual_edge_select;
  wire [`DELAY_W-1:0]      stop1_enable_delay;
  wire [5:0]               offset_code;
  wire                     first_wave_enable;
  wire                     first_wave_edge_select;
  wire [`FWC_COUNT_W-1:0]  stop1_period_count;
  wire [`FWC_COUNT_W-1:0]  stop2_period_count;
  wire [`FWC_COUNT_W-1:0]  stop3_period_count;
  wire [`FWC_COUNT_W-1:0]  stop4_period_count;
  wire [`FWC_COUNT_W-1:0]  stop5_period_count;
  wire [`FWC_COUNT_W*`NUM_STOPS-1:0] period_counts;
  wire                     hit_rise;
  wire                     hit_fall;
  wire                     hit_edge;
  wire                     fw_edge;
  wire                     fw_arrive;
  wire                     delay_fire;
  wire [`NUM_STOPS-1:0]    stop_fire;
  wire [`IRQ_W-1:0]        irq_events;
  wire                     status_read;

  // ---------------- field decode ----------------
  assign irq_timeout_allow      = stop_timing_config_reg[`STC_IRQ_TIMEOUT_BIT];
  assign irq_hits_allow         = stop_timing_config_reg[`STC_IRQ_HITS_BIT];
  assign irq_calc_done_allow    = stop_timing_config_reg[`STC_IRQ_CALC_BIT];
  assign dual_edge_select       = stop_timing_config_reg[`STC_DUAL_EDGE_BIT];
  assign stop1_enable_delay     = stop_timing_config_reg[`STC_DELAY_MSB:`STC_DELAY_LSB];
  assign offset_code            = stop_timing_config_reg[`STC_OFFSET_MSB:`STC_OFFSET_LSB];
  assign first_wave_enable      = first_wave_config_reg[`FWC_ENABLE_BIT];
  assign first_wave_edge_select = first_wave_config_reg[`FWC_EDGE_BIT];
  assign stop1_period_count     = first_wave_config_reg[`FWC_STOP1_LSB +: `FWC_COUNT_W];
  assign stop2_period_count     = first_wave_config_reg[`FWC_STOP2_LSB +: `FWC_COUNT_W];
  assign stop3_period_count     = first_wave_config_reg[`FWC_STOP3_LSB +: `FWC_COUNT_W];
  assign stop4_period_count     = first_wave_config_reg[`FWC_STOP4_LSB +: `FWC_COUNT_W];
  assign stop5_period_count     = first_wave_config_reg[`FWC_STOP5_LSB +: `FWC_COUNT_W];
  assign period_counts = {stop5_period_count, stop4_period_count, stop3_period_count,
                          stop2_period_count, stop1_period_count};

  // ---------------- AXI4-Lite write path ----------------
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready  = !w_held_reg && !bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign wr_go         = aw_held_reg && w_held_reg && !bvalid_reg;

  always @(posedge mclk_i) begin
    if (srst_i) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= {`ADDR_W{1'b0}};
      w_held_reg  <= 1'b0;
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        case (aw_addr_reg)
          `OFS_STOP_TIMING_CONFIG,
          `OFS_FIRST_WAVE_CONFIG,
          `OFS_IRQ_MASK:            bresp_reg <= `RESP_OKAY;
          default:                  bresp_reg <= `RESP_SLVERR;
        endcase
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always @(posedge mclk_i) begin
    if (srst_i) begin
      stop_timing_config_reg <= `STC_RESET;
      first_wave_config_reg  <= `FWC_RESET;
      irq_mask_reg           <= `IRQ_MASK_RESET;
    end else if (wr_go) begin
      case (aw_addr_reg)
        `OFS_STOP_TIMING_CONFIG: begin
          stop_timing_config_reg <= lane_merge(stop_timing_config_reg, w_data_reg, w_strb_reg);
        end
        `OFS_FIRST_WAVE_CONFIG: begin
          first_wave_config_reg <= lane_merge(first_wave_config_reg, w_data_reg, w_strb_reg);
        end
        `OFS_IRQ_MASK: begin
          if (w_strb_reg[0]) begin
            irq_mask_reg <= w_data_reg[`IRQ_W-1:0];
          end
        end
        default: begin
          irq_mask_reg <= irq_mask_reg;
        end
      endcase
    end
  end

  // ---------------- AXI4-Lite read path ----------------
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign rd_go         = s_axi_arvalid && !rvalid_reg;
  assign status_read   = rd_go && (s_axi_araddr == `OFS_IRQ_STATUS);

  always @(posedge mclk_i) begin
    if (srst_i) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h00000000;
      rresp_reg  <= `RESP_OKAY;
    end else if (rd_go) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= `RESP_OKAY;
      case (s_axi_araddr)
        // configuration words give no readback, so the host keeps its own copy
        `OFS_STOP_TIMING_CONFIG,
        `OFS_FIRST_WAVE_CONFIG:  rdata_reg <= 32'h00000000;
        `OFS_IRQ_STATUS:         rdata_reg <= {29'h0, irq_status_reg};
        `OFS_IRQ_MASK:           rdata_reg <= {29'h0, irq_mask_reg};
        `OFS_CORE_STATUS:        rdata_reg <= {24'h0, stop_done_reg, state_reg == ST_COUNT,
                                               fw_seen_reg, stop1_en_reg};
        default: begin
          rdata_reg <= 32'h00000000;
          rresp_reg <= `RESP_SLVERR;
        end
      endcase
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ---------------- interrupts ----------------
  assign irq_events = {calc_done_evt_i && irq_calc_done_allow,
                       hits_done_evt_i && irq_hits_allow,
                       timeout_evt_i && irq_timeout_allow};

  always @* begin
    irq_status_next = irq_status_reg;
    if (status_read) begin
      irq_status_next = {`IRQ_W{1'b0}};
    end
    // an event in the clearing cycle survives the read
    irq_status_next = irq_status_next | irq_events;
  end

  always @(posedge mclk_i) begin
    if (srst_i) begin
      irq_status_reg <= {`IRQ_W{1'b0}};
    end else begin
      irq_status_reg <= irq_status_next;
    end
  end

  assign irq_o = |(irq_status_reg & irq_mask_reg);

  // ---------------- comparator offset ----------------
  always @(posedge mclk_i) begin
    if (srst_i) begin
      offset_mv_reg <= 8'sh00;
    end else begin
      // sign-extended code times the step; full range -128..124 fits eight bits
      offset_mv_reg <= {offset_code, 2'b00};
    end
  end

  assign comp_offset_mv_o = offset_mv_reg;

  // ---------------- hit edges ----------------
  assign hit_rise = hit_i && !hit_d_reg;
  assign hit_fall = !hit_i && hit_d_reg;
  // single-edge mode watches the rising edge; polarity is set upstream of this pin
  assign hit_edge = stop1_en_reg &&
                    (dual_edge_select ? (hit_rise || hit_fall) : hit_rise);
  assign fw_edge  = stop1_en_reg &&
                    edge_pick(hit_rise, hit_fall, first_wave_edge_select);
  assign fw_arrive = (state_reg == ST_WAIT) && fw_edge;

  always @(posedge mclk_i) begin
    if (srst_i) begin
      hit_d_reg <= 1'b0;
    end else begin
      hit_d_reg <= hit_i;
    end
  end

  assign hit_edge_o = hit_edge;

  // ---------------- stop enable delay for hit 1 ----------------
  period_counter #(
    .W (`DELAY_W)
  ) u_stop1_delay (
    .mclk_i     (mclk_i),
    .srst_i     (srst_i),
    .load_i     (start_i),
    .load_val_i (stop1_enable_delay),
    .tick_i     (1'b1),
    .abort_i    (1'b0),
    .busy_o     (),
    .fire_o     (delay_fire)
  );

  always @(posedge mclk_i) begin
    if (srst_i) begin
      stop1_en_reg <= 1'b0;
    end else if (start_i) begin
      stop1_en_reg <= 1'b0;
    end else if (delay_fire) begin
      stop1_en_reg <= 1'b1;
    end
  end

  assign stop1_enable_o = stop1_en_reg;

  // ---------------- first-wave sequencer ----------------
  always @* begin
    case (state_reg)
      ST_IDLE: begin
        state_next = (start_i && first_wave_enable) ? ST_WAIT : ST_IDLE;
      end
      ST_WAIT: begin
        state_next = fw_arrive ? ST_COUNT : ST_WAIT;
      end
      ST_COUNT: begin
        state_next = (&(stop_done_reg | stop_fire)) ? ST_IDLE : ST_COUNT;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // disabling detection drops any sequence in flight
    if (!first_wave_enable || (start_i && state_reg != ST_IDLE)) begin
      state_next = (start_i && first_wave_enable) ? ST_WAIT : ST_IDLE;
    end
  end

  always @(posedge mclk_i) begin
    if (srst_i) begin
      state_reg     <= ST_IDLE;
      fw_seen_reg   <= 1'b0;
      stop_done_reg <= {`NUM_STOPS{1'b0}};
    end else begin
      state_reg <= state_next;
      if (start_i) begin
        fw_seen_reg   <= 1'b0;
        stop_done_reg <= {`NUM_STOPS{1'b0}};
      end else begin
        if (fw_arrive) begin
          fw_seen_reg <= 1'b1;
        end
        stop_done_reg <= stop_done_reg | stop_fire;
      end
    end
  end

  assign first_wave_seen_o = fw_seen_reg;

  // each stop counts signal periods of the first-wave polarity after the first hit
  genvar g;
  generate
    for (g = 0; g < `NUM_STOPS; g = g + 1) begin : g_stop
      period_counter #(
        .W (`FWC_COUNT_W)
      ) u_stop_cnt (
        .mclk_i     (mclk_i),
        .srst_i     (srst_i),
        .load_i     (fw_arrive),
        .load_val_i (period_counts[g*`FWC_COUNT_W +: `FWC_COUNT_W]),
        .tick_i     (fw_edge && (state_reg == ST_COUNT)),
        .abort_i    (!first_wave_enable || start_i),
        .busy_o     (),
        .fire_o     (stop_fire[g])
      );
    end
  endgenerate

  assign stop_pulse_o = stop_fire;

endmodule // tdc_stop_firstwave_config

// >>> verification/tdc_cfg_monitor.sv
// port checker for the configuration block
`timescale 1ns/1ps
`include "tdc_cfg_defs.vh"
module tdc_cfg_monitor (
  input wire                  mclk_i,
  input wire                  srst_i,
  input wire                  s_axi_awvalid,
  input wire                  s_axi_awready,
  input wire                  s_axi_wvalid,
  input wire                  s_axi_wready,
  input wire [1:0]            s_axi_bresp,
  input wire                  s_axi_bvalid,
  input wire                  s_axi_bready,
  input wire                  s_axi_arvalid,
  input wire                  s_axi_arready,
  input wire [31:0]           s_axi_rdata,
  input wire                  s_axi_rvalid,
  input wire                  s_axi_rready,
  input wire                  start_i,
  input wire                  hit_i,
  input wire                  stop1_enable_o,
  input wire                  hit_edge_o,
  input wire                  first_wave_seen_o,
  input wire [`NUM_STOPS-1:0] stop_pulse_o,
  input wire signed [7:0]     comp_offset_mv_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_b_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  property p_wr_ans; s_wr_taken |-> ##[1:2] s_axi_bvalid; endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
  property p_b_hold; s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_b_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_b_block: assert property (p_b_block) else $error("write taken early");
  property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_start_off; start_i |=> !stop1_enable_o && !first_wave_seen_o; endproperty
  a_start_off: assert property (p_start_off) else $error("stop open after start");
  property p_edge_gate; hit_edge_o |-> stop1_enable_o && hit_i != $past(hit_i); endproperty
  a_edge_gate: assert property (p_edge_gate) else $error("hit edge while stop closed");
  property p_step; comp_offset_mv_o[1:0] == 2'h0; endproperty
  a_step: assert property (p_step) else $error("offset off step");
  property p_stop_once; |stop_pulse_o |=> (stop_pulse_o & $past(stop_pulse_o)) == 0; endproperty
  a_stop_once: assert property (p_stop_once) else $error("stop pulse too long");
  property p_stop_wave; |stop_pulse_o |-> first_wave_seen_o; endproperty
  a_stop_wave: assert property (p_stop_wave) else $error("stop before first wave");
  property p_wave_gate; $rose(first_wave_seen_o) |-> $past(stop1_enable_o); endproperty
  a_wave_gate: assert property (p_wave_gate) else $error("wave while stop closed");
endmodule // tdc_cfg_monitor

bind tdc_stop_firstwave_config tdc_cfg_monitor u_tdc_cfg_monitor (
  .mclk_i(mclk_i), .srst_i(srst_i), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .start_i(start_i),
  .stop1_enable_o(stop1_enable_o), .hit_edge_o(hit_edge_o),
  .first_wave_seen_o(first_wave_seen_o), .stop_pulse_o(stop_pulse_o), .hit_i(hit_i),
  .comp_offset_mv_o(comp_offset_mv_o));

// >>> verification/host_bus_model.sv
// host side: AXI4-Lite master keeping a copy of each written configuration word
`timescale 1ns/1ps
module host_bus_model (
  input  wire         mclk_i,
  output logic [4:0]  s_axi_awaddr = 5'h0,
  output logic        s_axi_awvalid = 1'b0,
  input  wire         s_axi_awready,
  output logic [31:0] s_axi_wdata = 32'h0,
  output logic [3:0]  s_axi_wstrb = 4'hF,
  output logic        s_axi_wvalid = 1'b0,
  input  wire         s_axi_wready,
  input  wire  [1:0]  s_axi_bresp,
  input  wire         s_axi_bvalid,
  output logic        s_axi_bready = 1'b0,
  output logic [4:0]  s_axi_araddr = 5'h0,
  output logic        s_axi_arvalid = 1'b0,
  input  wire         s_axi_arready,
  input  wire  [31:0] s_axi_rdata,
  input  wire  [1:0]  s_axi_rresp,
  input  wire         s_axi_rvalid,
  output logic        s_axi_rready = 1'b0
);
  // no readback exists, so this copy is the only record
  logic [31:0] shadow_q [0:1];
  task write_word(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_left;
    logic w_left;
    begin
      @(posedge mclk_i);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      aw_left = 1'b1;
      w_left = 1'b1;
      while (aw_left || w_left) begin
        @(posedge mclk_i);
        if (aw_left && s_axi_awready) begin
          aw_left = 1'b0;
          s_axi_awvalid <= 1'b0;
          s_axi_awaddr <= ~a;
        end
        if (w_left && s_axi_wready) begin
          w_left = 1'b0;
          s_axi_wvalid <= 1'b0;
          s_axi_wdata <= ~d;
        end
      end
      while (!s_axi_bvalid) @(posedge mclk_i);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (a == 5'h00 || a == 5'h04) shadow_q[a[2]] = d;
    end
  endtask
  task read_word(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    begin
      @(posedge mclk_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      @(posedge mclk_i);
      while (!s_axi_arready) @(posedge mclk_i);
      s_axi_arvalid <= 1'b0;
      s_axi_araddr <= ~a;
      @(posedge mclk_i);
      while (!s_axi_rvalid) @(posedge mclk_i);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
    end
  endtask
endmodule // host_bus_model

// >>> verification/testbench.sv
// self-checking bench for the configuration block
`timescale 1ns/1ps
`include "tdc_cfg_defs.vh"
module testbench;
  logic        mclk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        start_i = 1'b0;
  logic        hit_i = 1'b0;
  logic [2:0]  evt = 3'h0;
  wire  [4:0]  awaddr, araddr, stop_pulse_o;
  wire  [31:0] wdata, rdata;
  wire  [3:0]  wstrb;
  wire  [1:0]  bresp, rresp;
  wire         awvalid, awready, wvalid, wready, bvalid, bready;
  wire         arvalid, arready, rvalid, rready, stop1_en, hit_edge, wave_seen, irq_o;
  wire  [7:0]  offset_mv;
  logic [5:0]  ofs_code [0:3] = '{6'h00, 6'h1F, 6'h20, 6'h3F};
  logic [7:0]  ofs_mv [0:3] = '{8'h00, 8'h7C, 8'h80, 8'hFC};
  logic [31:0] rd;
  logic [1:0]  rr;
  logic        en;
  logic        fe;
  int          err_count = 0;
  int          cmp_count = 0;
  int          edges = 0, edge_cnt = 0;
  int          n;
  int          seen_at [0:4];
  always #12.5 mclk_i = ~mclk_i;
  tdc_stop_firstwave_config u_tdc_stop_firstwave_config (
    .mclk_i(mclk_i), .srst_i(srst_i), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .start_i(start_i), .hit_i(hit_i), .timeout_evt_i(evt[0]), .hits_done_evt_i(evt[1]),
    .calc_done_evt_i(evt[2]), .stop1_enable_o(stop1_en), .hit_edge_o(hit_edge),
    .first_wave_seen_o(wave_seen), .stop_pulse_o(stop_pulse_o),
    .comp_offset_mv_o(offset_mv), .irq_o(irq_o));
  host_bus_model u_host_bus_model (
    .mclk_i(mclk_i), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  // start clears the capture so each run is judged alone
  always @(posedge mclk_i) begin
    if (start_i) begin
      seen_at <= '{default: 0};
      edge_cnt <= 0;
    end
    if (hit_edge === 1'b1) edge_cnt <= edge_cnt + 1;
    for (int i = 0; i < 5; i++) if (stop_pulse_o[i] === 1'b1) seen_at[i] <= edges;
  end
  task check(input string nm, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, s);
    end
  endtask
  task wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] e);
    u_host_bus_model.write_word(a, d, rr);
    check("bresp", {30'h0, rr}, {30'h0, e});
  endtask
  task rdc(input logic [4:0] a, input logic [31:0] e, input logic [1:0] er);
    u_host_bus_model.read_word(a, rd, rr);
    check("rdata", rd, e);
    check("rresp", {30'h0, rr}, {30'h0, er});
  endtask
  task pulse(input int i);
    @(posedge mclk_i);
    evt[i] <= 1'b1;
    @(posedge mclk_i);
    evt <= 3'h0;
    repeat (2) @(posedge mclk_i);
  endtask
  task kick;
    @(posedge mclk_i);
    start_i <= 1'b1;
    @(posedge mclk_i);
    start_i <= 1'b0;
    #1;
  endtask
  task give_verdict;
    $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #500000;
    err_count++;
    give_verdict();
  end
  initial begin
    repeat (4) @(posedge mclk_i);
    srst_i <= 1'b0;
    rdc(`OFS_IRQ_MASK, 32'h7, `RESP_OKAY);
    pulse(0);
    check("irq", {31'h0, irq_o}, 32'h0);
    pulse(2);
    check("irq", {31'h0, irq_o}, 32'h1);
    rdc(`OFS_IRQ_STATUS, 32'h4, `RESP_OKAY);
    check("irq", {31'h0, irq_o}, 32'h0);
    wr(`OFS_STOP_TIMING_CONFIG, 32'hE0000000, `RESP_OKAY);
    for (int i = 0; i < 3; i++) begin
      pulse(i);
      check("irq", {31'h0, irq_o}, 32'h1);
      rdc(`OFS_IRQ_STATUS, 32'h1 << i, `RESP_OKAY);
    end
    wr(`OFS_IRQ_MASK, 32'h0, `RESP_OKAY);
    pulse(1);
    check("irq", {31'h0, irq_o}, 32'h0);
    rdc(`OFS_IRQ_STATUS, 32'h2, `RESP_OKAY);
    wr(`OFS_IRQ_MASK, 32'h7, `RESP_OKAY);
    rdc(`OFS_STOP_TIMING_CONFIG, 32'h0, `RESP_OKAY);
    wr(`OFS_CORE_STATUS, 32'h1, `RESP_SLVERR);
    rdc(5'h14, 32'h0, `RESP_SLVERR);
    for (int i = 0; i < 4; i++) begin
      wr(`OFS_STOP_TIMING_CONFIG, {26'h0800000, ofs_code[i]}, `RESP_OKAY);
      repeat (2) @(posedge mclk_i);
      check("offset", {24'h0, offset_mv}, {24'h0, ofs_mv[i]});
    end
    for (int d = 0; d < 8; d += 7) begin
      wr(`OFS_STOP_TIMING_CONFIG, 32'h20000000 | (d << 6), `RESP_OKAY);
      kick();
      n = 0;
      while (stop1_en !== 1'b1 && n < 100) begin
        @(posedge mclk_i);
        #1;
        n++;
      end
      check("stop1 delay", n, d + 1);
    end
    for (int m = 0; m < 4; m++) begin
      en = (m == 1 || m == 2);
      fe = (m == 2);
      wr(`OFS_STOP_TIMING_CONFIG, {3'h1, m == 3, 28'h0}, `RESP_OKAY);
      wr(`OFS_FIRST_WAVE_CONFIG, {en, fe, 6'd3, 6'd4, 6'd5, 6'd6, 6'd7}, `RESP_OKAY);
      kick();
      edges = 0;
      repeat (4) @(posedge mclk_i);
      repeat (9) begin
        @(posedge mclk_i);
        hit_i <= 1'b1;
        edges += !fe;
        repeat (2) @(posedge mclk_i);
        hit_i <= 1'b0;
        edges += fe;
        @(posedge mclk_i);
      end
      repeat (4) @(posedge mclk_i);
      check("wave seen", {31'h0, wave_seen}, {31'h0, en});
      check("hit edges", edge_cnt, m == 3 ? 18 : 9);
      for (int i = 0; i < 5; i++) check("stop", seen_at[i], en ? 4 + i : 0);
    end
    give_verdict();
  end
endmodule // testbench
